// ===== hw/tms_pkg.sv
// Constants, opcodes, register map and state types for the touch matrix command block.
// Assumes one aclk domain; the serial link clock is sampled, not used as a clock.
package tms_pkg;
  localparam int KEYS       = 64;
  // Opcodes
  localparam logic [7:0] OP_KEY    = 8'h73;
  localparam logic [7:0] OP_ALL    = 8'h53;
  localparam logic [7:0] OP_ROW    = 8'h78;
  localparam logic [7:0] OP_COL    = 8'h79;
  localparam logic [7:0] OP_GET    = 8'h67;
  localparam logic [7:0] OP_PUT    = 8'h70;
  localparam logic [7:0] OP_SIG    = 8'h30;
  localparam logic [7:0] OP_DELTA  = 8'h31;
  localparam logic [7:0] OP_REF    = 8'h32;
  localparam logic [7:0] OP_LADDER = 8'h33;
  localparam logic [7:0] OP_CANCEL = 8'h34;
  localparam logic [7:0] OP_INTEG  = 8'h35;
  localparam logic [7:0] OP_CKSUM  = 8'h36;
  localparam logic [7:0] OP_STATUS = 8'h37;
  localparam logic [1:0] CANCEL_MAX = 2'h2;
  localparam logic [7:0] IDLE_BYTE  = 8'h00;
  // Register byte addresses
  localparam logic [7:0] REG_FLAGS    = 8'h00;
  localparam logic [7:0] REG_KEY_ADDR = 8'h04;
  localparam logic [7:0] REG_KEY_DATA = 8'h08;
  localparam logic [7:0] REG_KEY_CANC = 8'h0c;
  localparam logic [7:0] REG_NV_ADDR  = 8'h10;
  localparam logic [7:0] REG_NV_DATA  = 8'h14;
  localparam logic [7:0] REG_STATE    = 8'h18;
  // Reset values
  localparam logic [3:0] FLAGS_RST  = 4'h0;
  localparam logic [2:0] COORD_RST  = 3'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SCOPE_ALL = 2'b00,
    SCOPE_ROW = 2'b01,
    SCOPE_COL = 2'b10,
    SCOPE_KEY = 2'b11
  } tms_scope_e;

  typedef enum logic [1:0] {
    LINK_CMD  = 2'b00,
    LINK_ARG  = 2'b01,
    LINK_RESP = 2'b10
  } tms_link_e;
endpackage

// ===== hw/tms_scope_status.sv
// Serial command interpreter for scope selection and single-key status queries,
// with an AXI4-Lite slave that loads key data and setup store and shows state.
// Assumes spi_* pins are asynchronous to aclk; sclk half period at least 4 aclk cycles.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module tms_scope_status
  import tms_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Per-key acquisition data and the nonvolatile setup store
  logic [7:0] key_signal     [KEYS];
  logic [7:0] key_reference  [KEYS];
  logic [7:0] ladder_offset  [KEYS];
  logic [7:0] key_integrator [KEYS];
  logic [1:0] cancel_capacitor [KEYS];
  logic [7:0] setup_store    [KEYS];

  // Link synchronisers
  logic [2:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] mosi_sync;
  logic [2:0] bit_cnt;
  logic [6:0] rx_sh;
  logic [7:0] tx_sh;
  tms_link_e  link_state;
  logic [7:0] pend_op;

  // Command state
  tms_scope_e scope_mode;
  logic [2:0] tgt_row;
  logic [2:0] tgt_col;
  logic       put_mode;
  logic [5:0] scan_idx;

  // Checksum walk
  logic [6:0] ck_idx;
  logic [7:0] ck_acc;
  logic       nv_dirty;

  // Register file
  logic [3:0] flags;
  logic [5:0] key_addr;
  logic [5:0] nv_addr;
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Link decode
  wire        sclk_rise  = sclk_sync[1] & ~sclk_sync[2];
  wire        sclk_fall  = ~sclk_sync[1] & sclk_sync[2];
  wire        selected   = ~cs_sync[1];
  wire        byte_done  = selected & sclk_rise & (bit_cnt == 3'h7);
  wire [7:0]  rx_byte    = {rx_sh, mosi_sync[1]};
  wire [5:0]  tgt_key    = {tgt_col, tgt_row};
  wire [7:0]  sig_v      = key_signal[tgt_key];
  wire [7:0]  ref_v      = key_reference[tgt_key];
  wire [7:0]  delta_v    = (sig_v > ref_v) ? 8'h00 : 8'(ref_v - sig_v);
  wire [7:0]  status_v   = {3'h0, nv_dirty, flags};
  wire        ck_busy    = ~ck_idx[6];
  wire [8:0]  ck_sum     = {1'b0, ck_acc} + {1'b0, setup_store[ck_idx[5:0]]};
  wire        arg_ok_key = (rx_byte[7:6] == 2'h0);
  wire        arg_ok_rc  = (rx_byte[7:3] == 5'h00);

  // Data queries put only the value on the wire; no echo.
  logic [7:0] query_v;
  logic       query_hit;
  always_comb begin
    query_hit = 1'b1;
    case (rx_byte)
      OP_SIG:    query_v = sig_v;
      OP_DELTA:  query_v = delta_v;
      OP_REF:    query_v = ref_v;
      OP_LADDER: query_v = ladder_offset[tgt_key];
      OP_CANCEL: query_v = {6'h00, cancel_capacitor[tgt_key]};
      OP_INTEG:  query_v = key_integrator[tgt_key];
      OP_CKSUM:  query_v = ck_acc;
      OP_STATUS: query_v = status_v;
      default: begin
        query_v   = IDLE_BYTE;
        query_hit = 1'b0;
      end
    endcase
  end

  wire one_byte_scope = (rx_byte == OP_ALL) | (rx_byte == OP_GET) | (rx_byte == OP_PUT);
  wire two_byte_scope = (rx_byte == OP_KEY) | (rx_byte == OP_ROW) | (rx_byte == OP_COL);
  wire arg_valid = (pend_op == OP_KEY) ? arg_ok_key : arg_ok_rc;

  always_ff @(posedge aclk) begin
    sclk_sync <= {sclk_sync[1:0], spi_sclk};
    cs_sync   <= {cs_sync[0], spi_cs_n};
    mosi_sync <= {mosi_sync[0], spi_mosi};
  end

  // Bit shifting, mode 0, MSB first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt     <= 3'h0;
      rx_sh       <= 7'h00;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= selected;
      if (!selected)
        bit_cnt <= 3'h0;
      else if (sclk_rise) begin
        bit_cnt <= 3'(bit_cnt + 3'h1);
        rx_sh   <= rx_byte[6:0];
      end
    end
  end

  assign spi_miso = tx_sh[7];

  // Command interpreter; the reply is shifted out during the host's next byte.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_state <= LINK_CMD;
      pend_op    <= IDLE_BYTE;
      tx_sh      <= IDLE_BYTE;
      scope_mode <= SCOPE_ALL;
      tgt_row    <= COORD_RST;
      tgt_col    <= COORD_RST;
      put_mode   <= 1'b0;
    end else if (byte_done) begin
      case (link_state)
        LINK_RESP: begin
          // Clocking byte for the reply; its content is discarded
          link_state <= LINK_CMD;
          tx_sh      <= IDLE_BYTE;
        end
        LINK_ARG: begin
          // Targeting ignores put_mode entirely.
          if (arg_valid) begin
            link_state <= LINK_RESP;
            tx_sh      <= pend_op;
            case (pend_op)
              OP_KEY: begin
                tgt_row    <= rx_byte[2:0];
                tgt_col    <= rx_byte[5:3];
                scope_mode <= SCOPE_KEY;
              end
              OP_ROW: begin
                tgt_row    <= rx_byte[2:0];
                scope_mode <= SCOPE_ROW;
              end
              default: begin
                tgt_col    <= rx_byte[2:0];
                scope_mode <= SCOPE_COL;
              end
            endcase
          end else begin
            // Out-of-range operand: command dropped like an unknown opcode
            link_state <= LINK_CMD;
            tx_sh      <= IDLE_BYTE;
          end
        end
        default: begin
          if (two_byte_scope) begin
            pend_op    <= rx_byte;
            link_state <= LINK_ARG;
            tx_sh      <= IDLE_BYTE;
          end else if (one_byte_scope) begin
            link_state <= LINK_RESP;
            tx_sh      <= rx_byte;
            if (rx_byte == OP_ALL)
              scope_mode <= SCOPE_ALL;
            else
              put_mode <= (rx_byte == OP_PUT);
          end else if (query_hit) begin
            link_state <= LINK_RESP;
            tx_sh      <= query_v;
          end else begin
            tx_sh <= IDLE_BYTE;
          end
        end
      endcase
    end else if (selected && sclk_fall && bit_cnt != 3'h0) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // Acquisition sweep: the index counts up, so row advances before column.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      scan_idx <= 6'h00;
    else
      scan_idx <= 6'(scan_idx + 6'h01);
  end

  // Checksum is folded once after reset; later setup writes leave it stale
  // until the next reset; the host must reset before trusting it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_idx <= 7'h00;
      ck_acc <= 8'h00;
    end else if (ck_busy) begin
      ck_idx <= 7'(ck_idx + 7'h01);
      ck_acc <= 8'(ck_sum[7:0] + {7'h00, ck_sum[8]});
    end
  end

  // AXI4-Lite write channel; address and data taken in either order
  wire       wr_go   = aw_held & w_held & ~s_axi_bvalid;
  wire       wr_key  = wr_go & (aw_addr == REG_KEY_DATA);
  wire       wr_canc = wr_go & (aw_addr == REG_KEY_CANC);
  wire       wr_nv   = wr_go & (aw_addr == REG_NV_DATA);
  wire       wr_map  = (aw_addr == REG_FLAGS) | (aw_addr == REG_KEY_ADDR) |
                       (aw_addr == REG_KEY_DATA) | (aw_addr == REG_KEY_CANC) |
                       (aw_addr == REG_NV_ADDR) | (aw_addr == REG_NV_DATA) |
                       (aw_addr == REG_STATE);
  wire [1:0] canc_in = (w_data[1:0] > CANCEL_MAX) ? CANCEL_MAX : w_data[1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // Setup register writes; byte lane 0 carries every narrow field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags    <= FLAGS_RST;
      key_addr <= 6'h00;
      nv_addr  <= 6'h00;
      nv_dirty <= 1'b0;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == REG_FLAGS)
        flags <= w_data[3:0];
      if (aw_addr == REG_KEY_ADDR)
        key_addr <= w_data[5:0];
      if (aw_addr == REG_NV_ADDR)
        nv_addr <= w_data[5:0];
      // Flag comes from the write itself, not from the checksum.
      if (aw_addr == REG_NV_DATA)
        nv_dirty <= 1'b1;
    end
  end

  // Memory writes, one generate slice per key
  for (genvar k = 0; k < KEYS; k++) begin : g_key
    always_ff @(posedge aclk) begin
      if (wr_key && key_addr == 6'(k)) begin
        if (w_strb[0]) key_signal[k]     <= w_data[7:0];
        if (w_strb[1]) key_reference[k]  <= w_data[15:8];
        if (w_strb[2]) ladder_offset[k]  <= w_data[23:16];
        if (w_strb[3]) key_integrator[k] <= w_data[31:24];
      end
      if (wr_canc && w_strb[0] && key_addr == 6'(k))
        cancel_capacitor[k] <= canc_in;
      if (wr_nv && w_strb[0] && nv_addr == 6'(k))
        setup_store[k] <= w_data[7:0];
    end
  end

  // AXI4-Lite read channel
  logic [31:0] rd_word;
  logic        rd_map;
  always_comb begin
    rd_map  = 1'b1;
    case (s_axi_araddr)
      REG_FLAGS:    rd_word = {28'h0, flags};
      REG_KEY_ADDR: rd_word = {26'h0, key_addr};
      REG_KEY_DATA: rd_word = {key_integrator[key_addr], ladder_offset[key_addr],
                               key_reference[key_addr], key_signal[key_addr]};
      REG_KEY_CANC: rd_word = {30'h0, cancel_capacitor[key_addr]};
      REG_NV_ADDR:  rd_word = {26'h0, nv_addr};
      REG_NV_DATA:  rd_word = {24'h0, setup_store[nv_addr]};
      REG_STATE:    rd_word = {ck_acc, 2'h0, scan_idx, 5'h00, ~ck_busy, nv_dirty,
                               put_mode, tgt_col, tgt_row, scope_mode};
      default: begin
        rd_word = 32'h0;
        rd_map  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== testbench/tms_scope_status_monitor.sv
// Assertion checker for the touch matrix command block, bound to its top module.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/100ps
module tms_scope_status_monitor
  import tms_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        spi_cs_n,
  input wire logic        spi_miso_oe,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Checked through reset itself, so the default disable is overridden
  AST_RST_QUIET: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !spi_miso_oe) else $error("outputs active in reset");
  // Response is registered behind the held address and data, so it lands two edges on
  AST_B_AFTER: assert property (aw_w_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("no write response");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_AFTER: assert property (ar_taken |=> s_axi_rvalid) else $error("no read response");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_UNMAPPED: assert property (ar_taken ##0 (s_axi_araddr[7:5] != 3'h0) |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  AST_OE_SELECT: assert property ($fell(spi_cs_n) |-> ##[1:5] spi_miso_oe)
    else $error("miso not driven when selected");
  AST_OE_IDLE: assert property (spi_cs_n [*8] |-> !spi_miso_oe) else $error("miso driven idle");
endmodule

bind tms_scope_status tms_scope_status_monitor mon (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .spi_cs_n      (spi_cs_n),
  .spi_miso_oe   (spi_miso_oe),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready)
);

// ===== testbench/tms_host_model.sv
// Host-side serial master: clocks command, operand and dummy bytes, mode 0.
// Assumes a 320 ns serial clock that stands still low outside frames.
`timescale 1ns/100ps
module tms_host_model (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  // One byte, MSB first; the reply bit is taken at the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      #160;
      spi_sclk = 1'b1;
      rx[i] = spi_miso;
      #160;
      spi_sclk = 1'b0;
    end
  endtask
  // Operands stay in range unless a refusal is wanted
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input bit two,
                     input int gap, output logic [7:0] rep);
    logic [7:0] junk;
    #7;
    xfer(op, junk);
    if (two) xfer(arg, junk);
    #(gap);
    xfer(8'h00, rep);
    #160;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    // Idle long enough to cover an ignored opcode
    #433;
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench: AXI4-Lite loads key data and setup store, host model queries.
// Assumes the monitor is bound to the design from its own file.
`timescale 1ns/100ps
module testbench;
  import tms_pkg::*;
  logic        aclk, aresetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rep, ck_old;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, flags;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  sig_m [64], ref_m [64], lad_m [64], int_m [64], nv_m [64];
  logic [1:0]  can_m [64];
  int          err_total, samples_checked, gap, k;

  tms_scope_status dut (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .spi_sclk      (spi_sclk),
    .spi_cs_n      (spi_cs_n),
    .spi_mosi      (spi_mosi),
    .spi_miso      (spi_miso),
    .spi_miso_oe   (spi_miso_oe),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );
  tms_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
                       .spi_miso(spi_miso));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    $display("Error at %0t: wait ran out", $time);
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) tmo();
    check(s_axi_bresp, er);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) tmo();
  endtask
  task automatic sc(input logic [7:0] op, input logic [7:0] arg, input bit two,
                    input logic [7:0] exp);
    host.cmd(op, arg, two, gap, rep);
    check(rep, exp);
  endtask
  // Fields: put mode, column, row, scope
  task automatic st(input logic [8:0] exp);
    rdr(REG_STATE);
    check(rd[8:0], exp);
  endtask
  task automatic reset_wait();
    int n;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    do begin
      rdr(REG_STATE);
      n++;
    end while (rd[10] !== 1'b1 && n < 40);
    if (rd[10] !== 1'b1) tmo();
  endtask
  function automatic logic [7:0] eac();
    logic [8:0] s;
    s = 9'h0;
    for (int i = 0; i < 64; i++) begin
      s = {1'b0, s[7:0]} + nv_m[i];
      s = s[7:0] + s[8];
    end
    return s[7:0];
  endfunction
  function automatic logic [7:0] qexp(input int j, input int q);
    case (j)
      0: return sig_m[q];
      1: return (sig_m[q] > ref_m[q]) ? 8'h00 : ref_m[q] - sig_m[q];
      2: return ref_m[q];
      3: return lad_m[q];
      4: return {6'h0, can_m[q]};
      default: return int_m[q];
    endcase
  endfunction

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    samples_checked = 0;
    gap = 0;
    void'($urandom(32'h65ca));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    st(9'h000);
    rdr(8'h40);
    check({rs, rd}, {RESP_SLVERR, 32'h0});
    wr(8'h44, 32'h1, RESP_SLVERR);
    for (int q = 0; q < 64; q++) begin
      {int_m[q], lad_m[q], ref_m[q], sig_m[q]} = $urandom;
      nv_m[q] = $urandom;
      can_m[q] = $urandom_range(2);
      wr(REG_KEY_ADDR, q, RESP_OKAY);
      wr(REG_KEY_DATA, {int_m[q], lad_m[q], ref_m[q], sig_m[q]}, RESP_OKAY);
      wr(REG_KEY_CANC, can_m[q], RESP_OKAY);
      wr(REG_NV_ADDR, q, RESP_OKAY);
      wr(REG_NV_DATA, nv_m[q], RESP_OKAY);
    end
    flags = $urandom;
    wr(REG_FLAGS, flags, RESP_OKAY);
    sc(OP_STATUS, 0, 0, {3'h0, 1'b1, flags});
    reset_wait();
    ck_old = eac();
    sc(OP_CKSUM, 0, 0, ck_old);
    sc(OP_STATUS, 0, 0, 8'h00);
    nv_m[5] = nv_m[5] + 8'h01;
    wr(REG_NV_ADDR, 5, RESP_OKAY);
    wr(REG_NV_DATA, nv_m[5], RESP_OKAY);
    sc(OP_STATUS, 0, 0, 8'h10);
    sc(OP_CKSUM, 0, 0, ck_old);
    reset_wait();
    sc(OP_CKSUM, 0, 0, eac());
    // Walk of key 9, then all keys, then row 2 and column 3
    sc(OP_KEY, 9, 1, OP_KEY);
    st(9'h027);
    sc(OP_ALL, 0, 0, OP_ALL);
    st(9'h024);
    sc(OP_ROW, 2, 1, OP_ROW);
    sc(OP_SIG, 0, 0, sig_m[10]);
    sc(OP_COL, 3, 1, OP_COL);
    sc(OP_SIG, 0, 0, sig_m[26]);
    sc(OP_ROW, 8, 1, 8'h00);
    sc(OP_KEY, 64, 1, 8'h00);
    sc(8'h41, 0, 0, 8'h00);
    st(9'h06a);
    for (int m = 0; m < 2; m++) begin
      sc(m ? OP_PUT : OP_GET, 0, 0, m ? OP_PUT : OP_GET);
      for (int t = 0; t < 4; t++) begin
        k = (t == 0) ? 0 : $urandom_range(63);
        gap = $urandom_range(3) * 97;
        sc(OP_KEY, k, 1, OP_KEY);
        for (int j = 0; j < 6; j++) begin
          sc(OP_SIG + j, 0, 0, qexp(j, k));
        end
      end
    end
    st({1'b1, 6'(k), 2'h3});
    reset_wait();
    st(9'h000);
    final_report();
  end
endmodule
